// ### rtl/uas_pkg.sv
// Shared constants of the audio serial port with stream pacing
`default_nettype none
package uas_pkg;
	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam longint CLK_HZ = 100_000_000;
	localparam int CLK_PERIOD_NS = 10;
	localparam longint SAMPLE_HZ = 48_000;
	localparam int SOF_PERIOD_NS = 1_000_000;
	localparam int SOF_CYCLES_DFLT = SOF_PERIOD_NS / CLK_PERIOD_NS;
	localparam int BITS_PER_FRAME = 32;
	localparam int SYNC_FRAMES = 16;
	// Half bit-clock ticks at 2 * 32 * fs, as a 32-bit phase step
	localparam logic [31:0] NCO_NOMINAL = 32'((64'h0000_0001_0000_0000 * 64'(2 * BITS_PER_FRAME) * 64'(SAMPLE_HZ))
		/ 64'(CLK_HZ));
	localparam int MCLK_SHIFT = 3;
	localparam logic [31:0] TRIM_STEP = 32'h0000_1000;
	// ---------------------------------------------------------------
	// Register offsets
	// ---------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_LOW_MARK = 8'h04;
	localparam logic [7:0] OFS_HIGH_MARK = 8'h08;
	localparam logic [7:0] OFS_LARGE_PKT = 8'h0C;
	localparam logic [7:0] OFS_SMALL_PKT = 8'h10;
	localparam logic [7:0] OFS_NOMINAL_PKT = 8'h14;
	localparam logic [7:0] OFS_STATUS = 8'h18;
	localparam logic [7:0] OFS_RATE = 8'h1C;
	// ---------------------------------------------------------------
	// Fields and codes
	// ---------------------------------------------------------------
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_DIR_BIT = 2;
	localparam int CTRL_EN_BIT = 3;
	localparam logic [1:0] MODE_ASYNC = 2'h0;
	localparam logic [1:0] MODE_ADAPTIVE = 2'h1;
	localparam logic [1:0] MODE_SYNC = 2'h2;
	localparam int STAT_IN_LSB = 0;
	localparam int STAT_OUT_LSB = 8;
	localparam int STAT_MIC_BIT = 16;
	localparam int STAT_OVR_BIT = 17;
	localparam int STAT_UND_BIT = 18;
	// ---------------------------------------------------------------
	// Reset values
	// ---------------------------------------------------------------
	localparam logic [3:0] CTRL_RST = 4'h0;
	localparam logic [3:0] LOW_MARK_RST = 4'h2;
	localparam logic [3:0] HIGH_MARK_RST = 4'h6;
	localparam logic [15:0] LARGE_PKT_RST = 16'h00C4;
	localparam logic [15:0] SMALL_PKT_RST = 16'h00BC;
	localparam logic [15:0] NOMINAL_PKT_RST = 16'h00C0;
endpackage
`default_nettype wire

// ### rtl/uas_port.sv
// Audio serial port with FIFO pacing and sample clock trimming
//
// Strobed register access and the address map were decided locally.
`default_nettype none

// ---------------------------------------------------------------
// Sample FIFO
// ---------------------------------------------------------------
module uas_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output var logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output var logic out_valid,
	input wire logic out_ready,
	output var logic [$clog2(DEPTH+1)-1:0] level
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH+1);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_r, rd_ptr_r;
	logic [CW-1:0] count_nxt;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;
	wire [AW-1:0] wr_inc = (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
	wire [AW-1:0] rd_inc = (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
	assign count_nxt = (push && !pop) ? level + 1'b1 : (pop && !push) ? level - 1'b1 : level;
	assign out_data = mem[rd_ptr_r];
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr_r] <= in_data;
		end
	end
	// Ready and valid are registered so neither side sees a combinational path
	always_ff @(posedge clk) begin
		if (rst) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			level <= '0;
			in_ready <= 1'b0;
			out_valid <= 1'b0;
		end else begin
			wr_ptr_r <= push ? wr_inc : wr_ptr_r;
			rd_ptr_r <= pop ? rd_inc : rd_ptr_r;
			level <= count_nxt;
			in_ready <= count_nxt != CW'(DEPTH);
			out_valid <= count_nxt != '0;
		end
	end
endmodule

// ---------------------------------------------------------------
// Port top
// ---------------------------------------------------------------
module uas_port #(
	parameter int SOF_CYCLES = uas_pkg::SOF_CYCLES_DFLT,
	parameter int FIFO_DEPTH = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic [31:0] host_out_data,
	input wire logic host_out_valid,
	output logic host_out_ready,
	output logic [31:0] host_in_data,
	output logic host_in_valid,
	input wire logic host_in_ready,
	input wire logic sof,
	output logic [15:0] pkt_size,
	input wire logic audio_serial_in,
	output logic audio_serial_out,
	output logic audio_bit_clock,
	output logic audio_word_select,
	output logic audio_master_clock,
	input wire logic microphone_plug_detect
);
	import uas_pkg::*;
	localparam int LW = $clog2(FIFO_DEPTH+1);

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	logic [3:0] ctrl_r, low_mark_r, high_mark_r;
	logic [15:0] large_pkt_r, small_pkt_r, nominal_pkt_r, pkt_size_r;
	logic [31:0] rdata_r, incr_r, incr_nxt;
	logic ovr_r, und_r;
	logic [LW-1:0] in_level, out_level;
	logic si_s1_r, si_s2_r, si_s3_r, si_f_r, md_s1_r, md_s2_r, md_s3_r, md_f_r;

	wire [1:0] mode = ctrl_r[CTRL_MODE_LSB +: 2];
	wire transmit = ctrl_r[CTRL_DIR_BIT];
	wire enable = ctrl_r[CTRL_EN_BIT];
	wire wr_ctrl = reg_wr && reg_addr == OFS_CTRL;
	wire wr_stat = reg_wr && reg_addr == OFS_STATUS;
	wire [31:0] status = 32'({und_r, ovr_r, md_f_r, 8'(out_level), 8'(in_level)});
	wire [31:0] rd_mux =
		(reg_addr == OFS_CTRL) ? 32'(ctrl_r) :
		(reg_addr == OFS_LOW_MARK) ? 32'(low_mark_r) :
		(reg_addr == OFS_HIGH_MARK) ? 32'(high_mark_r) :
		(reg_addr == OFS_LARGE_PKT) ? 32'(large_pkt_r) :
		(reg_addr == OFS_SMALL_PKT) ? 32'(small_pkt_r) :
		(reg_addr == OFS_NOMINAL_PKT) ? 32'(nominal_pkt_r) :
		(reg_addr == OFS_STATUS) ? status :
		(reg_addr == OFS_RATE) ? incr_r : 32'h0000_0000;

	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl_r <= CTRL_RST;
			low_mark_r <= LOW_MARK_RST;
			high_mark_r <= HIGH_MARK_RST;
			large_pkt_r <= LARGE_PKT_RST;
			small_pkt_r <= SMALL_PKT_RST;
			nominal_pkt_r <= NOMINAL_PKT_RST;
			rdata_r <= 32'h0000_0000;
		end else begin
			ctrl_r <= wr_ctrl ? reg_wdata[3:0] : ctrl_r;
			low_mark_r <= (reg_wr && reg_addr == OFS_LOW_MARK) ? reg_wdata[3:0] : low_mark_r;
			high_mark_r <= (reg_wr && reg_addr == OFS_HIGH_MARK) ? reg_wdata[3:0] : high_mark_r;
			large_pkt_r <= (reg_wr && reg_addr == OFS_LARGE_PKT) ? reg_wdata[15:0] : large_pkt_r;
			small_pkt_r <= (reg_wr && reg_addr == OFS_SMALL_PKT) ? reg_wdata[15:0] : small_pkt_r;
			nominal_pkt_r <= (reg_wr && reg_addr == OFS_NOMINAL_PKT) ? reg_wdata[15:0] : nominal_pkt_r;
			rdata_r <= reg_rd ? rd_mux : 32'h0000_0000;
		end
	end
	assign reg_rdata = rdata_r;

	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	// A change is taken only once the second and third stages agree
	always_ff @(posedge clk) begin
		if (rst) begin
			{si_s1_r, si_s2_r, si_s3_r, si_f_r} <= 4'h0;
			{md_s1_r, md_s2_r, md_s3_r, md_f_r} <= 4'h0;
		end else begin
			{si_s1_r, si_s2_r, si_s3_r} <= {audio_serial_in, si_s1_r, si_s2_r};
			si_f_r <= (si_s2_r == si_s3_r) ? si_s3_r : si_f_r;
			{md_s1_r, md_s2_r, md_s3_r} <= {microphone_plug_detect, md_s1_r, md_s2_r};
			md_f_r <= (md_s2_r == md_s3_r) ? md_s3_r : md_f_r;
		end
	end

	// ---------------------------------------------------------------
	// Frame pacing and rate tracking
	// ---------------------------------------------------------------
	logic [31:0] win_cnt_r;
	logic [4:0] frame_cnt_r;
	logic armed_r;
	localparam logic [31:0] WIN_CYCLES = 32'(SOF_CYCLES * SYNC_FRAMES);
	wire in_high = in_level > LW'(high_mark_r);
	wire in_low = in_level < LW'(low_mark_r);
	wire out_high = out_level > LW'(high_mark_r);
	wire out_low = out_level < LW'(low_mark_r);
	wire adaptive = enable && mode == MODE_ADAPTIVE;
	wire syncing = enable && mode == MODE_SYNC;
	wire win_end = syncing && sof && armed_r && frame_cnt_r == 5'(SYNC_FRAMES - 1);
	wire raise = (adaptive && sof && out_high) || (win_end && win_cnt_r < WIN_CYCLES);
	wire lower = (adaptive && sof && out_low) || (win_end && win_cnt_r > WIN_CYCLES);
	// Outside tracking the rate sits at nominal, so adaptive starts there unless entered straight from sync mode
	assign incr_nxt = !(adaptive || syncing) ? NCO_NOMINAL :
		raise ? incr_r + TRIM_STEP :
		lower ? incr_r - TRIM_STEP : incr_r;
	wire [15:0] pkt_nxt = in_high ? large_pkt_r : in_low ? small_pkt_r : nominal_pkt_r;

	// Averaging over many frames trades lock speed for jitter rejection
	always_ff @(posedge clk) begin
		if (rst || !syncing) begin
			win_cnt_r <= 32'h0000_0000;
			frame_cnt_r <= 5'h00;
			armed_r <= 1'b0;
		end else if (sof) begin
			armed_r <= 1'b1;
			win_cnt_r <= (!armed_r || win_end) ? 32'h0000_0000 : win_cnt_r + 1'b1;
			frame_cnt_r <= (!armed_r || win_end) ? 5'h00 : frame_cnt_r + 1'b1;
		end else begin
			win_cnt_r <= win_cnt_r + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			incr_r <= NCO_NOMINAL;
			pkt_size_r <= NOMINAL_PKT_RST;
		end else begin
			incr_r <= incr_nxt;
			pkt_size_r <= sof ? pkt_nxt : pkt_size_r;
		end
	end
	assign pkt_size = pkt_size_r;

	// ---------------------------------------------------------------
	// Clock generation
	// ---------------------------------------------------------------
	logic [31:0] bacc_r, macc_r;
	logic [32:0] bsum, msum;
	logic bclk_r, mclk_r, ws_r, sdo_r;
	logic [4:0] bit_cnt_r;
	logic [31:0] tx_sh_r, rx_sh_r;
	assign bsum = {1'b0, bacc_r} + {1'b0, incr_r};
	assign msum = {1'b0, macc_r} + {1'b0, 32'(incr_r << MCLK_SHIFT)};
	wire tick = bsum[32];
	wire rise = tick && !bclk_r;
	wire fall = tick && bclk_r;
	wire frame_wrap = fall && bit_cnt_r == 5'(BITS_PER_FRAME - 1);

	// ---------------------------------------------------------------
	// FIFOs
	// ---------------------------------------------------------------
	logic in_ready, out_valid;
	logic [31:0] out_word;
	// Word select leads the word by one bit, so the LSB lands on the rise after the wrap
	wire rx_wrap = rise && bit_cnt_r == 5'h00;
	wire rx_push = rx_wrap && enable && !transmit;
	wire tx_pop = frame_wrap && enable && transmit && out_valid;

	uas_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) in_fifo (
		.clk(clk), .rst(rst),
		.in_data({rx_sh_r[30:0], si_f_r}), .in_valid(rx_push), .in_ready(in_ready),
		.out_data(host_in_data), .out_valid(host_in_valid), .out_ready(host_in_ready),
		.level(in_level)
	);
	uas_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) out_fifo (
		.clk(clk), .rst(rst),
		.in_data(host_out_data), .in_valid(host_out_valid), .in_ready(host_out_ready),
		.out_data(out_word), .out_valid(out_valid), .out_ready(tx_pop),
		.level(out_level)
	);

	// ---------------------------------------------------------------
	// Serial engine
	// ---------------------------------------------------------------
	// Data is shifted out on falling bit clock, sampled on rising
	always_ff @(posedge clk) begin
		if (rst) begin
			bacc_r <= 32'h0000_0000;
			macc_r <= 32'h0000_0000;
			bclk_r <= 1'b0;
			mclk_r <= 1'b0;
			ws_r <= 1'b0;
			sdo_r <= 1'b0;
			bit_cnt_r <= 5'h00;
			tx_sh_r <= 32'h0000_0000;
			rx_sh_r <= 32'h0000_0000;
			ovr_r <= 1'b0;
			und_r <= 1'b0;
		end else begin
			bacc_r <= bsum[31:0];
			macc_r <= msum[31:0];
			bclk_r <= tick ? !bclk_r : bclk_r;
			mclk_r <= msum[32] ? !mclk_r : mclk_r;
			if (rise) begin
				rx_sh_r <= {rx_sh_r[30:0], si_f_r};
			end
			if (fall) begin
				bit_cnt_r <= bit_cnt_r + 1'b1;
				ws_r <= bit_cnt_r[4] ^ (bit_cnt_r[3:0] == 4'hF);
				tx_sh_r <= frame_wrap ? (tx_pop ? out_word : 32'h0000_0000) : {tx_sh_r[30:0], 1'b0};
				sdo_r <= (enable && transmit) ? tx_sh_r[31] : 1'b0;
			end
			// Hardware set wins over a software clear in the same cycle
			ovr_r <= (rx_push && !in_ready) || (ovr_r && !wr_stat);
			und_r <= (frame_wrap && enable && transmit && !out_valid) || (und_r && !wr_stat);
		end
	end
	assign audio_bit_clock = bclk_r;
	assign audio_master_clock = mclk_r;
	assign audio_word_select = ws_r;
	assign audio_serial_out = sdo_r;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	chk_async_rate_fixed: assert property (enable && mode == MODE_ASYNC |=> incr_r == NCO_NOMINAL)
		else $error("async rate moved off nominal");
	chk_large_packet: assert property (sof && in_high |=> pkt_size == $past(large_pkt_r))
		else $error("large packet not chosen");
	chk_small_packet: assert property (sof && in_low |=> pkt_size == $past(small_pkt_r))
		else $error("small packet not chosen");
	chk_nominal_packet: assert property (sof && !in_high && !in_low |=> pkt_size == $past(nominal_pkt_r))
		else $error("nominal packet not chosen");
	chk_adaptive_raise: assert property (adaptive && sof && out_high |=> incr_r == $past(incr_r) + TRIM_STEP)
		else $error("rate not raised");
	chk_adaptive_hold: assert property (adaptive && sof && !out_high && !out_low |=> $stable(incr_r))
		else $error("rate changed between marks");
	chk_adaptive_lower: assert property (adaptive && sof && out_low |=> incr_r == $past(incr_r) - TRIM_STEP)
		else $error("rate not lowered");
	chk_receive_quiet: assert property (!transmit && !$past(transmit) && fall |=> !audio_serial_out)
		else $error("output driven while receiving");
	chk_sync_slow_host: assert property (win_end && win_cnt_r > WIN_CYCLES |=> incr_r < $past(incr_r))
		else $error("slow host did not lower rate");
	chk_sync_fast_host: assert property (win_end && win_cnt_r < WIN_CYCLES |=> incr_r > $past(incr_r))
		else $error("fast host did not raise rate");
	chk_pkt_frame_only: assert property (!sof |=> $stable(pkt_size))
		else $error("packet size changed outside frame");
endmodule
`default_nettype wire

// ### testbench/uas_codec_model.sv
// Behavioural codec on the far side of the audio serial port
`default_nettype none
module uas_codec_model #(
	parameter logic [31:0] CAP_WORD = 32'hA5C3_1234
) (
	input wire logic audio_bit_clock,
	input wire logic audio_word_select,
	input wire logic audio_serial_out,
	output logic audio_serial_in,
	output logic microphone_plug_detect,
	input wire logic mic_plugged,
	output logic [31:0] rx_word
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [4:0] slot_r = 5'h0;
	logic ws_seen_r = 1'b0;
	logic [31:0] shift_r = 32'h0000_0000;
	initial audio_serial_in = 1'b0;
	initial rx_word = 32'h0000_0000;
	assign microphone_plug_detect = mic_plugged;
	// Word select moves on the same edge, so look just after it
	always @(negedge audio_bit_clock) begin
		#1;
		slot_r = (ws_seen_r && !audio_word_select) ? 5'h0 : slot_r - 5'h1;
		ws_seen_r = audio_word_select;
		audio_serial_in = CAP_WORD[slot_r];
	end
	// Last bit of a frame lands in slot zero
	always @(posedge audio_bit_clock) begin
		shift_r = {shift_r[30:0], audio_serial_out};
		if (slot_r == 5'h0) begin
			rx_word = shift_r;
		end
	end
endmodule
`default_nettype wire

// ### testbench/uas_port_tb_top.sv
// Self-checking bench of the audio serial port with stream pacing
`default_nettype none
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin n_fail++; $display("wrong value at %0t: %h not %h", $time, got, exp); end end
module uas_port_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import uas_pkg::*;
	localparam logic [31:0] CAP_WORD = 32'hA5C3_1235;
	localparam logic [31:0] PLAY_WORD = 32'h1357_9BDF;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic [31:0] host_out_data = 32'h0000_0000;
	logic host_out_valid = 1'b0;
	logic host_out_ready;
	logic [31:0] host_in_data;
	logic host_in_valid;
	logic host_in_ready = 1'b0;
	logic sof = 1'b0;
	logic [15:0] pkt_size;
	logic sdi, sdo, bclk, ws, mclk, mic;
	logic mic_plugged = 1'b1;
	logic [31:0] rx_word;
	logic [31:0] d;
	int n_fail = 0;
	int checks = 0;
	int m_edges = 0;
	int m_first = 0;
	logic [7:0] ofs [7] = '{OFS_LOW_MARK, OFS_HIGH_MARK, OFS_LARGE_PKT, OFS_SMALL_PKT, OFS_NOMINAL_PKT, OFS_RATE, 8'h20};
	logic [31:0] rv [7] = '{32'h2, 32'h6, 32'hC4, 32'hBC, 32'hC0, NCO_NOMINAL, 32'h0};
	always #5 clk = ~clk;
	always @(posedge mclk) m_edges++;
	uas_port #(.SOF_CYCLES(200), .FIFO_DEPTH(8)) dut (.clk(clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.host_out_data(host_out_data), .host_out_valid(host_out_valid), .host_out_ready(host_out_ready),
		.host_in_data(host_in_data), .host_in_valid(host_in_valid), .host_in_ready(host_in_ready),
		.sof(sof), .pkt_size(pkt_size), .audio_serial_in(sdi), .audio_serial_out(sdo),
		.audio_bit_clock(bclk), .audio_word_select(ws), .audio_master_clock(mclk),
		.microphone_plug_detect(mic));
	uas_codec_model #(.CAP_WORD(CAP_WORD)) codec (.audio_bit_clock(bclk), .audio_word_select(ws),
		.audio_serial_out(sdo), .audio_serial_in(sdi), .microphone_plug_detect(mic),
		.mic_plugged(mic_plugged), .rx_word(rx_word));
	// ---------------------------------------------------------------
	// Bus and stream tasks
	// ---------------------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask
	task automatic sof_train(input int n, input int gap);
		repeat (n) begin
			@(posedge clk);
			sof <= 1'b1;
			@(posedge clk);
			sof <= 1'b0;
			repeat (gap - 2) @(posedge clk);
		end
		@(posedge clk);
		#1;
	endtask
	task automatic wait_level(input logic [7:0] lvl);
		int i;
		d = 32'h0000_00FF;
		for (i = 0; i < 6000 && d[7:0] !== lvl; i++) rd(OFS_STATUS, d);
		`CHK(d[7:0], lvl)
	endtask
	task automatic push(input logic [31:0] w);
		int i;
		@(posedge clk);
		host_out_data <= w;
		host_out_valid <= 1'b1;
		for (i = 0; i < 100; i++) begin
			@(posedge clk);
			if (host_out_ready === 1'b1) break;
		end
		host_out_valid <= 1'b0;
	endtask
	task automatic end_sim();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// ---------------------------------------------------------------
	// Tests
	// ---------------------------------------------------------------
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		#1 `CHK(pkt_size, NOMINAL_PKT_RST)
		for (int i = 0; i < 7; i++) begin
			rd(ofs[i], d);
			`CHK(d, rv[i])
		end
		wr(OFS_RATE, 32'h0000_0000);
		rd(OFS_RATE, d);
		`CHK(d, NCO_NOMINAL)
		rd(OFS_STATUS, d);
		`CHK(d[STAT_MIC_BIT], 1'b1)
		// Codec aligns on a word select fall before capture starts
		repeat (2) @(negedge ws);
		wr(OFS_CTRL, 32'h0000_0008);
		sof_train(1, 4);
		`CHK(pkt_size, SMALL_PKT_RST)
		wait_level(8'h02);
		sof_train(1, 4);
		`CHK(pkt_size, NOMINAL_PKT_RST)
		wait_level(8'h06);
		sof_train(1, 4);
		`CHK(pkt_size, NOMINAL_PKT_RST)
		wait_level(8'h07);
		sof_train(1, 4);
		`CHK(pkt_size, LARGE_PKT_RST)
		rd(OFS_RATE, d);
		`CHK(d, NCO_NOMINAL)
		for (int i = 0; i < 3000 && d[STAT_OVR_BIT] !== 1'b1; i++) rd(OFS_STATUS, d);
		`CHK(d[STAT_OVR_BIT +: 1], 1'b1)
		`CHK(d[STAT_IN_LSB +: 8], 8'h08)
		wr(OFS_STATUS, 32'h0000_0000);
		wr(OFS_CTRL, 32'h0000_0000);
		rd(OFS_STATUS, d);
		`CHK(d[STAT_OVR_BIT], 1'b0)
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			#1 `CHK(host_in_valid, 1'b1)
			`CHK(host_in_data, CAP_WORD)
			@(posedge clk);
			host_in_ready <= 1'b1;
			@(posedge clk);
			host_in_ready <= 1'b0;
		end
		@(posedge clk);
		#1 `CHK(host_in_valid, 1'b0)
		// Adaptive playback trims the rate by OUT fill
		wr(OFS_CTRL, 32'h0000_000D);
		rd(OFS_RATE, d);
		`CHK(d, NCO_NOMINAL)
		sof_train(1, 4);
		rd(OFS_RATE, d);
		`CHK(d, NCO_NOMINAL - TRIM_STEP)
		// Empty OUT FIFO at a frame boundary sends zeros and flags it
		@(negedge ws);
		rd(OFS_STATUS, d);
		`CHK(d[STAT_UND_BIT], 1'b1)
		repeat (4) push(PLAY_WORD);
		sof_train(1, 4);
		rd(OFS_RATE, d);
		`CHK(d, NCO_NOMINAL - TRIM_STEP)
		repeat (4) push(PLAY_WORD);
		sof_train(1, 4);
		rd(OFS_RATE, d);
		`CHK(d, NCO_NOMINAL)
		for (int i = 0; i < 20000 && rx_word !== PLAY_WORD; i++) @(posedge clk);
		`CHK(rx_word, PLAY_WORD)
		// Synchronous mode: fast then slow frame markers
		wr(OFS_CTRL, 32'h0000_0000);
		wr(OFS_CTRL, 32'h0000_000A);
		sof_train(17, 190);
		rd(OFS_RATE, d);
		`CHK(d, NCO_NOMINAL + TRIM_STEP)
		wr(OFS_CTRL, 32'h0000_0000);
		rd(OFS_RATE, d);
		`CHK(d, NCO_NOMINAL)
		wr(OFS_CTRL, 32'h0000_000A);
		sof_train(17, 210);
		rd(OFS_RATE, d);
		`CHK(d, NCO_NOMINAL - TRIM_STEP)
		// Master clock runs at eight times the bit clock
		@(negedge ws);
		m_first = m_edges;
		@(negedge ws);
		`CHK((m_edges - m_first) inside {[254:258]}, 1'b1)
		@(posedge clk);
		mic_plugged <= 1'b0;
		repeat (4) @(posedge clk);
		rd(OFS_STATUS, d);
		`CHK(d[STAT_MIC_BIT], 1'b0)
		end_sim();
	end
	// Whole run needs well under half of this
	initial begin
		#900_000;
		n_fail++;
		end_sim();
	end
endmodule
`default_nettype wire
